// ==== logic/gasket_consts.vh ====
// Purpose: constants for the bus gasket configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: bit positions name the control fields of the config word
`ifndef GASKET_CONSTS_VH
`define GASKET_CONSTS_VH

`define DATA_W 32
`define ADDR_W 32
`define PADDR_W 12
`define CFG_ONE_OFFSET 12'h004
`define CFG_ONE_RESET 32'h0000_0000

// Core 1 data port
`define PRE_C1D_BIT 5
`define BRE_C1D_BIT 6
`define BWE_C1D_BIT 7
// Core 1 instruction port
`define PRE_C1I_BIT 13
`define BRE_C1I_BIT 14
`define BWE_C1I_BIT 15
// Core 0 data port
`define PRE_C0D_BIT 21
`define BRE_C0D_BIT 22
`define BWE_C0D_BIT 23

// Writable bits of the config word; all others read as zero
`define CFG_ONE_MASK 32'h00e0_e0e0

// Outstanding read counter
`define RD_CNT_W 2
`define RD_CNT_MAX 2'h3
`define RD_CNT_ZERO 2'h0
`define RD_CNT_ONE 2'h1

`endif

// ==== logic/burst_gasket.v ====
// Purpose: one master-port gasket; splits or forwards bursts
// Assumes: slave answers beats in issue order, one answer per beat
// Notes: a write waits for its answer before the next request
`timescale 1ns/100ps
`include "gasket_consts.vh"
module burst_gasket (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Controls from the config register
   input wire pending_read_en,
   input wire burst_read_en,
   input wire burst_write_en,
   // Master side request
   input wire m_valid,
   input wire m_write,
   input wire m_burst,
   input wire m_last,
   input wire [`ADDR_W-1:0] m_addr,
   input wire [`DATA_W-1:0] m_wdata,
   output reg m_ready,
   // Master side answer
   output reg m_resp_valid,
   output reg m_err,
   output reg [`DATA_W-1:0] m_rdata,
   // Slave side request
   output reg s_valid,
   output reg s_write,
   output reg s_burst,
   output reg s_last,
   output reg [`ADDR_W-1:0] s_addr,
   output reg [`DATA_W-1:0] s_wdata,
   input wire s_ready,
   // Slave side answer
   input wire s_resp_valid,
   input wire s_err,
   input wire [`DATA_W-1:0] s_rdata
);

reg [`RD_CNT_W-1:0] rd_out;
reg wr_busy;
reg wr_last;
reg wr_imp;
reg err_acc;
reg next_m_ready, next_m_resp_valid, next_m_err;
reg next_s_valid, next_s_write, next_s_burst, next_s_last;
reg [`ADDR_W-1:0] next_s_addr;
reg [`DATA_W-1:0] next_s_wdata;
reg [`RD_CNT_W-1:0] next_rd_out;
reg next_wr_busy, next_wr_last, next_wr_imp, next_err_acc;
reg accept;
reg opt;

always @* begin
   next_s_valid = s_valid;
   next_s_write = s_write;
   next_s_burst = s_burst;
   next_s_last = s_last;
   next_s_addr = s_addr;
   next_s_wdata = s_wdata;
   next_rd_out = rd_out;
   next_wr_busy = wr_busy;
   next_wr_last = wr_last;
   next_wr_imp = wr_imp;
   next_err_acc = err_acc;
   next_m_resp_valid = s_resp_valid;
   next_m_err = 1'b0;
   // A write is held back while reads are still in flight
   accept = m_valid & m_ready & (~m_write | (rd_out == `RD_CNT_ZERO));
   opt = m_write ? burst_write_en : burst_read_en;
   if (s_valid & s_ready) begin
      next_s_valid = 1'b0;
   end
   if (accept) begin
      next_s_valid = 1'b1;
      next_s_write = m_write;
      next_s_addr = m_addr;
      next_s_wdata = m_wdata;
      next_s_burst = m_burst & opt;
      // Split beats each stand alone on the slave side
      next_s_last = opt ? m_last : 1'b1;
      if (m_write) begin
         next_wr_busy = 1'b1;
         next_wr_last = m_last;
         next_wr_imp = m_burst & burst_write_en;
      end else begin
         next_rd_out = rd_out + `RD_CNT_ONE;
      end
   end
   if (s_resp_valid) begin
      if (wr_busy) begin
         next_wr_busy = 1'b0;
         if (wr_imp & ~wr_last) begin
            next_err_acc = err_acc | s_err;
         end else begin
            next_m_err = s_err | (wr_imp & err_acc);
            next_err_acc = 1'b0;
         end
      end else begin
         next_m_err = s_err;
         next_rd_out = next_rd_out - `RD_CNT_ONE;
      end
   end
   // Without pending reads only one read may be in flight
   next_m_ready = ~next_s_valid & ~next_wr_busy &
      ((next_rd_out == `RD_CNT_ZERO) |
       (pending_read_en & (next_rd_out != `RD_CNT_MAX)));
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      m_ready <= 1'b0;
      m_resp_valid <= 1'b0;
      m_err <= 1'b0;
      m_rdata <= {`DATA_W{1'b0}};
      s_valid <= 1'b0;
      s_write <= 1'b0;
      s_burst <= 1'b0;
      s_last <= 1'b0;
      s_addr <= {`ADDR_W{1'b0}};
      s_wdata <= {`DATA_W{1'b0}};
      rd_out <= `RD_CNT_ZERO;
      wr_busy <= 1'b0;
      wr_last <= 1'b0;
      wr_imp <= 1'b0;
      err_acc <= 1'b0;
   end else begin
      m_ready <= next_m_ready;
      m_resp_valid <= next_m_resp_valid;
      m_err <= next_m_err;
      m_rdata <= s_rdata;
      s_valid <= next_s_valid;
      s_write <= next_s_write;
      s_burst <= next_s_burst;
      s_last <= next_s_last;
      s_addr <= next_s_addr;
      s_wdata <= next_s_wdata;
      rd_out <= next_rd_out;
      wr_busy <= next_wr_busy;
      wr_last <= next_wr_last;
      wr_imp <= next_wr_imp;
      err_acc <= next_err_acc;
   end
end

endmodule // burst_gasket

// ==== logic/gasket_bridge_cfg.v ====
// Purpose: APB config register and three master-port bus gaskets
// Assumes: single clock pclk, asynchronous active-low presetn
// Notes: one wait state on every APB access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "gasket_consts.vh"
module gasket_bridge_cfg (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PADDR_W-1:0] paddr,
   input wire [`DATA_W-1:0] pwdata,
   output reg pready,
   output reg [`DATA_W-1:0] prdata,
   output reg pslverr,
   // Core 1 data master side
   input wire c1d_m_valid,
   input wire c1d_m_write,
   input wire c1d_m_burst,
   input wire c1d_m_last,
   input wire [`ADDR_W-1:0] c1d_m_addr,
   input wire [`DATA_W-1:0] c1d_m_wdata,
   output wire c1d_m_ready,
   output wire c1d_m_resp_valid,
   output wire c1d_m_err,
   output wire [`DATA_W-1:0] c1d_m_rdata,
   // Core 1 data slave side
   output wire c1d_s_valid,
   output wire c1d_s_write,
   output wire c1d_s_burst,
   output wire c1d_s_last,
   output wire [`ADDR_W-1:0] c1d_s_addr,
   output wire [`DATA_W-1:0] c1d_s_wdata,
   input wire c1d_s_ready,
   input wire c1d_s_resp_valid,
   input wire c1d_s_err,
   input wire [`DATA_W-1:0] c1d_s_rdata,
   // Core 1 instruction master side
   input wire c1i_m_valid,
   input wire c1i_m_write,
   input wire c1i_m_burst,
   input wire c1i_m_last,
   input wire [`ADDR_W-1:0] c1i_m_addr,
   input wire [`DATA_W-1:0] c1i_m_wdata,
   output wire c1i_m_ready,
   output wire c1i_m_resp_valid,
   output wire c1i_m_err,
   output wire [`DATA_W-1:0] c1i_m_rdata,
   // Core 1 instruction slave side
   output wire c1i_s_valid,
   output wire c1i_s_write,
   output wire c1i_s_burst,
   output wire c1i_s_last,
   output wire [`ADDR_W-1:0] c1i_s_addr,
   output wire [`DATA_W-1:0] c1i_s_wdata,
   input wire c1i_s_ready,
   input wire c1i_s_resp_valid,
   input wire c1i_s_err,
   input wire [`DATA_W-1:0] c1i_s_rdata,
   // Core 0 data master side
   input wire c0d_m_valid,
   input wire c0d_m_write,
   input wire c0d_m_burst,
   input wire c0d_m_last,
   input wire [`ADDR_W-1:0] c0d_m_addr,
   input wire [`DATA_W-1:0] c0d_m_wdata,
   output wire c0d_m_ready,
   output wire c0d_m_resp_valid,
   output wire c0d_m_err,
   output wire [`DATA_W-1:0] c0d_m_rdata,
   // Core 0 data slave side
   output wire c0d_s_valid,
   output wire c0d_s_write,
   output wire c0d_s_burst,
   output wire c0d_s_last,
   output wire [`ADDR_W-1:0] c0d_s_addr,
   output wire [`DATA_W-1:0] c0d_s_wdata,
   input wire c0d_s_ready,
   input wire c0d_s_resp_valid,
   input wire c0d_s_err,
   input wire [`DATA_W-1:0] c0d_s_rdata
);

// Config word; only the masked control bits have storage
reg [`DATA_W-1:0] gasket_bridge_config_one;
reg [`DATA_W-1:0] next_prdata;
reg next_pslverr;
wire hit;
wire access;
wire commit;

assign hit = (paddr == `CFG_ONE_OFFSET);
assign access = psel & penable;
// Write lands only at the edge that samples pready high
assign commit = access & pready;

always @* begin
   next_prdata = {`DATA_W{1'b0}};
   next_pslverr = 1'b0;
   if (hit) begin
      next_prdata = gasket_bridge_config_one & `CFG_ONE_MASK;
   end else begin
      next_pslverr = 1'b1;
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready <= 1'b0;
      prdata <= {`DATA_W{1'b0}};
      pslverr <= 1'b0;
      gasket_bridge_config_one <= `CFG_ONE_RESET;
   end else begin
      if (access & ~pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? {`DATA_W{1'b0}} : next_prdata;
         pslverr <= next_pslverr;
      end else begin
         pready <= 1'b0;
         prdata <= {`DATA_W{1'b0}};
         pslverr <= 1'b0;
      end
      if (commit & pwrite & hit) begin
         // Reserved bits never take a written one
         gasket_bridge_config_one <= pwdata & `CFG_ONE_MASK;
      end
   end
end

burst_gasket c1d_gasket (
   .pclk(pclk),
   .presetn(presetn),
   .pending_read_en(gasket_bridge_config_one[`PRE_C1D_BIT]),
   .burst_read_en(gasket_bridge_config_one[`BRE_C1D_BIT]),
   .burst_write_en(gasket_bridge_config_one[`BWE_C1D_BIT]),
   .m_valid(c1d_m_valid),
   .m_write(c1d_m_write),
   .m_burst(c1d_m_burst),
   .m_last(c1d_m_last),
   .m_addr(c1d_m_addr),
   .m_wdata(c1d_m_wdata),
   .m_ready(c1d_m_ready),
   .m_resp_valid(c1d_m_resp_valid),
   .m_err(c1d_m_err),
   .m_rdata(c1d_m_rdata),
   .s_valid(c1d_s_valid),
   .s_write(c1d_s_write),
   .s_burst(c1d_s_burst),
   .s_last(c1d_s_last),
   .s_addr(c1d_s_addr),
   .s_wdata(c1d_s_wdata),
   .s_ready(c1d_s_ready),
   .s_resp_valid(c1d_s_resp_valid),
   .s_err(c1d_s_err),
   .s_rdata(c1d_s_rdata)
);

burst_gasket c1i_gasket (
   .pclk(pclk),
   .presetn(presetn),
   .pending_read_en(gasket_bridge_config_one[`PRE_C1I_BIT]),
   .burst_read_en(gasket_bridge_config_one[`BRE_C1I_BIT]),
   .burst_write_en(gasket_bridge_config_one[`BWE_C1I_BIT]),
   .m_valid(c1i_m_valid),
   .m_write(c1i_m_write),
   .m_burst(c1i_m_burst),
   .m_last(c1i_m_last),
   .m_addr(c1i_m_addr),
   .m_wdata(c1i_m_wdata),
   .m_ready(c1i_m_ready),
   .m_resp_valid(c1i_m_resp_valid),
   .m_err(c1i_m_err),
   .m_rdata(c1i_m_rdata),
   .s_valid(c1i_s_valid),
   .s_write(c1i_s_write),
   .s_burst(c1i_s_burst),
   .s_last(c1i_s_last),
   .s_addr(c1i_s_addr),
   .s_wdata(c1i_s_wdata),
   .s_ready(c1i_s_ready),
   .s_resp_valid(c1i_s_resp_valid),
   .s_err(c1i_s_err),
   .s_rdata(c1i_s_rdata)
);

burst_gasket c0d_gasket (
   .pclk(pclk),
   .presetn(presetn),
   .pending_read_en(gasket_bridge_config_one[`PRE_C0D_BIT]),
   .burst_read_en(gasket_bridge_config_one[`BRE_C0D_BIT]),
   .burst_write_en(gasket_bridge_config_one[`BWE_C0D_BIT]),
   .m_valid(c0d_m_valid),
   .m_write(c0d_m_write),
   .m_burst(c0d_m_burst),
   .m_last(c0d_m_last),
   .m_addr(c0d_m_addr),
   .m_wdata(c0d_m_wdata),
   .m_ready(c0d_m_ready),
   .m_resp_valid(c0d_m_resp_valid),
   .m_err(c0d_m_err),
   .m_rdata(c0d_m_rdata),
   .s_valid(c0d_s_valid),
   .s_write(c0d_s_write),
   .s_burst(c0d_s_burst),
   .s_last(c0d_s_last),
   .s_addr(c0d_s_addr),
   .s_wdata(c0d_s_wdata),
   .s_ready(c0d_s_ready),
   .s_resp_valid(c0d_s_resp_valid),
   .s_err(c0d_s_err),
   .s_rdata(c0d_s_rdata)
);

endmodule // gasket_bridge_cfg

// ==== test/slave_model.sv ====
// Purpose: slave-side bus model for one gasket port
// Assumes: one answer per beat, one cycle after the beat is taken
// Notes: slow mode stalls each beat one cycle; idle read data churns
`timescale 1ns/100ps
module slave_model (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Behaviour controls
   input logic slow,
   input logic err_on,
   // Gasket slave side
   input logic valid,
   input logic [31:0] addr,
   output logic ready,
   output logic resp,
   output logic err,
   output logic [31:0] rdata
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready <= 1'b0;
         resp <= 1'b0;
         err <= 1'b0;
         rdata <= 32'h0;
      end else begin
         ready <= slow ? valid & !ready : 1'b1;
         resp <= valid & ready;
         // Only beats with address bit 8 set answer with an error
         err <= valid & ready & err_on & addr[8];
         // Inverting when idle keeps stale data from passing for valid
         rdata <= (valid & ready) ? addr ^ 32'ha5a5_0000 : ~rdata;
      end
   end
endmodule // slave_model

// ==== test/gasket_bridge_sva.sv ====
// Purpose: assertions on the gasket config block ports
// Assumes: one clock, asynchronous active-low reset
// Notes: cfg shadows the register from committed APB writes
`timescale 1ns/100ps
module gasket_bridge_sva (
   // APB side
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   // Gasket ports
   input wire c1d_m_valid,
   input wire c1d_m_write,
   input wire c1d_m_ready,
   input wire c1d_s_valid,
   input wire c1d_s_write,
   input wire c1d_s_burst,
   input wire c1d_s_last,
   input wire c1i_s_valid,
   input wire c1i_s_write,
   input wire c1i_s_burst,
   input wire c1i_s_last,
   input wire c0d_s_valid,
   input wire c0d_s_write,
   input wire c0d_s_burst,
   input wire c0d_s_last
);
   logic [31:0] cfg;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         cfg <= 32'h0;
      else if (psel && penable && pready && pwrite && paddr == 12'h004)
         cfg <= pwdata & 32'h00e0_e0e0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("no pulse");
   property p_resv; pready |-> (prdata & 32'hff1f_1f1f) == 32'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved set");
   property p_unmap;
      pready && paddr != 12'h004 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_rdback;
      pready && !pwrite && paddr == 12'h004 |-> prdata == cfg && !pslverr;
   endproperty
   a_rdback: assert property (p_rdback) else $error("rd data");
   property p_rsplit;
      c1d_s_valid && !c1d_s_write && !cfg[6] |-> !c1d_s_burst && c1d_s_last;
   endproperty
   a_rsplit: assert property (p_rsplit) else $error("rd split");
   property p_wsplit;
      c1i_s_valid && c1i_s_write && !cfg[15] |-> !c1i_s_burst && c1i_s_last;
   endproperty
   a_wsplit: assert property (p_wsplit) else $error("wr split");
   property p_c0w;
      c0d_s_valid && c0d_s_write && !cfg[23] |-> !c0d_s_burst && c0d_s_last;
   endproperty
   a_c0w: assert property (p_c0w) else $error("c0 wr split");
   property p_pend;
      c1d_m_valid && c1d_m_ready && !c1d_m_write && !cfg[5]
         |=> !c1d_m_ready [*2];
   endproperty
   a_pend: assert property (p_pend) else $error("pending");
endmodule // gasket_bridge_sva
bind gasket_bridge_cfg gasket_bridge_sva chk (.*);

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the gasket config block
// Assumes: all three ports see the same master traffic
// Notes: bit-to-port mapping shows as which port alone differs
`timescale 1ns/100ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b1, slow = 1'b0, err_on = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, ev;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rv, md;
   logic [2:0] sb, sl, me;
   logic m_valid = 1'b0, m_write = 1'b0, m_burst = 1'b0, m_last = 1'b0;
   logic [31:0] m_addr = 32'h0;
   int num_errors = 0, n_tests = 0, cyc = 0;
   wire c1d_m_valid = m_valid, c1i_m_valid = m_valid;
   wire c0d_m_valid = m_valid, c1d_m_write = m_write;
   wire c1i_m_write = m_write, c0d_m_write = m_write;
   wire c1d_m_burst = m_burst, c1i_m_burst = m_burst;
   wire c0d_m_burst = m_burst, c1d_m_last = m_last;
   wire c1i_m_last = m_last, c0d_m_last = m_last;
   wire [31:0] c1d_m_addr = m_addr, c1i_m_addr = m_addr;
   wire [31:0] c0d_m_addr = m_addr, c1d_m_wdata = ~m_addr;
   wire [31:0] c1i_m_wdata = ~m_addr, c0d_m_wdata = ~m_addr;
   logic c1d_m_ready, c1i_m_ready, c0d_m_ready;
   logic c1d_m_resp_valid, c1i_m_resp_valid, c0d_m_resp_valid;
   logic c1d_m_err, c1i_m_err, c0d_m_err;
   logic c1d_s_valid, c1i_s_valid, c0d_s_valid;
   logic c1d_s_write, c1i_s_write, c0d_s_write;
   logic c1d_s_burst, c1i_s_burst, c0d_s_burst;
   logic c1d_s_last, c1i_s_last, c0d_s_last;
   logic c1d_s_ready, c1i_s_ready, c0d_s_ready;
   logic c1d_s_resp_valid, c1i_s_resp_valid, c0d_s_resp_valid;
   logic c1d_s_err, c1i_s_err, c0d_s_err;
   logic [31:0] c1d_m_rdata, c1i_m_rdata, c0d_m_rdata;
   logic [31:0] c1d_s_addr, c1i_s_addr, c0d_s_addr;
   logic [31:0] c1d_s_wdata, c1i_s_wdata, c0d_s_wdata;
   logic [31:0] c1d_s_rdata, c1i_s_rdata, c0d_s_rdata;
   gasket_bridge_cfg dut (.*);
   slave_model sm0 (.*, .valid(c1d_s_valid), .addr(c1d_s_addr),
      .ready(c1d_s_ready), .resp(c1d_s_resp_valid), .err(c1d_s_err),
      .rdata(c1d_s_rdata));
   slave_model sm1 (.*, .valid(c1i_s_valid), .addr(c1i_s_addr),
      .ready(c1i_s_ready), .resp(c1i_s_resp_valid), .err(c1i_s_err),
      .rdata(c1i_s_rdata));
   slave_model sm2 (.*, .valid(c0d_s_valid), .addr(c0d_s_addr),
      .ready(c0d_s_ready), .resp(c0d_s_resp_valid), .err(c0d_s_err),
      .rdata(c0d_s_rdata));
   always #50 pclk = ~pclk;
   task tally_and_finish;
      $display("TB: %0d checks, %0d errors", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Reads of pready and data right after the edge see the sampled value
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task beat(input logic w, b, l, input logic [31:0] a);
      m_valid <= 1'b1;
      m_write <= w;
      m_burst <= b;
      m_last <= l;
      m_addr <= a;
      do @(posedge pclk); while (c1d_m_ready !== 1'b1);
      m_valid <= 1'b0;
      do @(posedge pclk); while (c1d_s_valid !== 1'b1);
      sb = {c0d_s_burst, c1i_s_burst, c1d_s_burst};
      sl = {c0d_s_last, c1i_s_last, c1d_s_last};
      chk({c0d_s_write, c1i_s_write, c1d_s_write}, {3{w}});
      chk(c1i_s_addr, a);
      chk(c0d_s_wdata, ~a);
      do @(posedge pclk); while (c1d_m_resp_valid !== 1'b1);
      me = {c0d_m_err, c1i_m_err, c1d_m_err};
      md = c1d_m_rdata;
      chk({c0d_m_resp_valid, c1i_m_resp_valid}, 2'b11);
      if (!w) begin
         chk(c1i_m_rdata, a ^ 32'ha5a5_0000);
         chk(c0d_m_rdata, a ^ 32'ha5a5_0000);
      end
   endtask
   task t_regs;
      apb(0, 12'h004, 32'h0);
      chk(rv, 32'h0);
      apb(1, 12'h004, 32'hffff_ffff);
      apb(0, 12'h004, 32'h0);
      chk(rv, 32'h00e0_e0e0);
      apb(1, 12'h008, 32'h0);
      chk(ev, 1'b1);
      apb(1, 12'h004, 32'h0000_001f);
      apb(0, 12'h004, 32'h0);
      chk(rv, 32'h0);
      $display("TB: regs done");
   endtask
   task t_burst;
      int bits[6] = '{6, 14, 22, 7, 15, 23};
      foreach (bits[i]) begin
         apb(1, 12'h004, 32'h1 << bits[i]);
         beat(bits[i] % 2, 1'b1, 1'b0, 32'h40);
         chk(sb, 32'h1 << (bits[i] / 8));
         chk(sl, 32'h7 ^ (32'h1 << (bits[i] / 8)));
      end
      beat(1'b0, 1'b0, 1'b1, 32'h44);
      chk(md, 32'h44 ^ 32'ha5a5_0000);
      $display("TB: burst done");
   endtask
   // Counts the edges at which each port could take a read
   task pend_run(input logic [31:0] cfg, output int n[3]);
      apb(1, 12'h004, cfg);
      n = '{0, 0, 0};
      m_valid <= 1'b1;
      m_write <= 1'b0;
      m_last <= 1'b1;
      repeat (12) begin
         @(posedge pclk);
         if (c1d_m_ready === 1'b1)
            n[0]++;
         if (c1i_m_ready === 1'b1)
            n[1]++;
         if (c0d_m_ready === 1'b1)
            n[2]++;
      end
      m_valid <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   // Bit 13 alone, then bits 5 and 21 together, so a misplaced bit shows on the wrong port
   task t_pend;
      int n0[3], n1[3], n2[3];
      pend_run(32'h0, n0);
      pend_run(32'h0000_2000, n1);
      pend_run(32'h0020_0020, n2);
      chk(n1[1] > n0[1], 32'h1);
      chk(n1[0] == n0[0] && n1[2] == n0[2], 32'h1);
      chk(n2[0] > n0[0], 32'h1);
      chk(n2[2] > n0[2], 32'h1);
      chk(n2[1] == n0[1], 32'h1);
      $display("TB: pending done");
   endtask
   task t_err(input logic [31:0] cfg, input logic [2:0] e1, e3);
      apb(1, 12'h004, cfg);
      err_on <= 1'b1;
      beat(1'b1, 1'b1, 1'b0, 32'h100);
      chk(me, e1);
      beat(1'b1, 1'b1, 1'b0, 32'h004);
      chk(me, 32'h0);
      beat(1'b1, 1'b1, 1'b1, 32'h008);
      chk(me, e3);
      $display("TB: error burst done");
   endtask
   initial begin
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_burst;
      t_pend;
      slow <= 1'b1;
      t_err(32'h80, 3'b110, 3'b001);
      t_err(32'h0080_0080, 3'b010, 3'b101);
      tally_and_finish;
   end
endmodule // testbench
